// ### core/port_pkg.sv
package port_pkg;

   // ---------------------------------------------------------------
   // Register map (byte addresses, one 32-bit word each)
   // ---------------------------------------------------------------
   localparam int             ADDR_W          = 8;
   localparam int             DATA_W          = 32;
   localparam int             PORT_W          = 8;
   localparam logic [ADDR_W-1:0] OFS_PIN_VALUES  = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_OUT_LATCH   = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_DIRECTION   = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_ANALOG_SEL  = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_CONTROL     = 8'h10;

   // ---------------------------------------------------------------
   // Reset values and implemented analog-select mask
   // ---------------------------------------------------------------
   localparam logic [7:0]     ANALOG_IMPL_MASK = 8'h2f;
   localparam logic [7:0]     ANALOG_RESET     = 8'h2f;
   localparam logic [7:0]     DIRECTION_RESET  = 8'hff;
   localparam logic [7:0]     LATCH_RESET      = 8'h00;
   localparam logic [3:0]     PIN_SELECT_RESET = 4'hf;

   // ---------------------------------------------------------------
   // Control register fields
   // ---------------------------------------------------------------
   localparam int             CTRL_OSC_LSB     = 0;
   localparam int             CTRL_CLKOUT_BIT  = 2;
   localparam int             CTRL_DAC_BIT     = 3;
   localparam int             CTRL_UNIT5_BIT   = 4;
   localparam int             CTRL_SR_BIT      = 5;
   localparam int             CTRL_PINSEL_LSB  = 6;

   // ---------------------------------------------------------------
   // Special pins and routed signals
   // ---------------------------------------------------------------
   localparam int             PIN_DAC          = 2;
   localparam int             PIN_UNIT5        = 4;
   localparam int             PIN_CLKOUT       = 6;
   localparam int             PIN_OSC_IN       = 7;
   localparam int             ROUTE_PWM2B      = 0;
   localparam int             ROUTE_TIMER3_CLK = 1;
   localparam int             ROUTE_UNIT3      = 2;
   localparam int             ROUTE_UNIT2      = 3;
   localparam int             ROUTE_N          = 4;

   // Clock out runs at one quarter of the oscillator
   localparam int             CLKOUT_DIV       = 4;
   localparam int             CLKOUT_DIV_W     = $clog2(CLKOUT_DIV);

   typedef enum logic [1:0] {
      OSC_INTERNAL = 2'b00,
      OSC_RC       = 2'b01,
      OSC_EXT_XTAL = 2'b10,
      OSC_EXT_CLK  = 2'b11
   } osc_mode_t;

endpackage : port_pkg

// ### core/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter int W = 8
) (
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic         ce_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] sync;
   } sync_state_t;

   sync_state_t state_q;
   sync_state_t state_d;

   // Only the second stage is read, so a metastable first stage never reaches logic
   always_comb begin
      state_d = state_q;
      if (ce_i) begin
         state_d.meta = d_i;
         state_d.sync = state_q.meta;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= '0;
      end else begin
         state_q <= state_d;
      end
   end

   assign q_o = state_q.sync;
endmodule // pin_sync
`default_nettype wire

// ### core/route_select.sv
`timescale 1ns/1ps
`default_nettype none
module route_select (
   input  wire logic sel_default_i,
   input  wire logic periph_out_i,
   input  wire logic periph_oe_i,
   input  wire logic pin_default_i,
   input  wire logic pin_alt_i,
   output logic      default_out_o,
   output logic      default_oe_o,
   output logic      alt_out_o,
   output logic      alt_oe_o,
   output logic      periph_in_o
);
   // Only the chosen pin ever sees the peripheral
   assign default_out_o = sel_default_i & periph_out_i;
   assign default_oe_o  = sel_default_i & periph_oe_i;
   assign alt_out_o     = ~sel_default_i & periph_out_i;
   assign alt_oe_o      = ~sel_default_i & periph_oe_i;
   assign periph_in_o   = sel_default_i ? pin_default_i : pin_alt_i;
endmodule // route_select
`default_nettype wire

// ### core/port_a_ctrl.sv
// The register addresses and the Wishbone register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module port_a_ctrl
   import port_pkg::*;
(
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire logic              ce_i,
   // Wishbone classic slave
   input  wire logic              cyc_i,
   input  wire logic              stb_i,
   input  wire logic              we_i,
   input  wire logic [ADDR_W-1:0] adr_i,
   input  wire logic [3:0]        sel_i,
   input  wire logic [DATA_W-1:0] dat_i,
   output logic      [DATA_W-1:0] dat_o,
   output logic                   ack_o,
   // Port A pins
   input  wire logic [PORT_W-1:0] port_a_pin_i,
   output logic      [PORT_W-1:0] port_a_out_o,
   output logic      [PORT_W-1:0] port_a_oe_o,
   output logic      [PORT_W-1:0] analog_connect_o,
   output logic                   dac_reference_output_o,
   // Peripheral drivers for bit 4
   input  wire logic              unit5_out_i,
   input  wire logic              sr_latch_true_out_i,
   // Routed peripheral signals
   input  wire logic [ROUTE_N-1:0] route_periph_out_i,
   input  wire logic [ROUTE_N-1:0] route_periph_oe_i,
   input  wire logic [ROUTE_N-1:0] route_pin_default_i,
   input  wire logic [ROUTE_N-1:0] route_pin_alt_i,
   output logic      [ROUTE_N-1:0] route_default_out_o,
   output logic      [ROUTE_N-1:0] route_default_oe_o,
   output logic      [ROUTE_N-1:0] route_alt_out_o,
   output logic      [ROUTE_N-1:0] route_alt_oe_o,
   output logic      [ROUTE_N-1:0] route_periph_in_o
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [PORT_W-1:0]       lat;
      logic [PORT_W-1:0]       dir;
      logic [PORT_W-1:0]       analog_select_register;
      osc_mode_t               osc;
      logic                    clkout_en;
      logic                    dac_en;
      logic                    unit5_en;
      logic                    sr_en;
      logic [ROUTE_N-1:0]      pinsel;
      logic [CLKOUT_DIV_W-1:0] div;
      logic                    ack;
      logic [DATA_W-1:0]       rdata;
   } state_t;

   localparam state_t STATE_RESET = '{
      lat:       LATCH_RESET,
      dir:       DIRECTION_RESET,
      analog_select_register:     ANALOG_RESET,
      osc:       OSC_INTERNAL,
      clkout_en: 1'b0,
      dac_en:    1'b0,
      unit5_en:  1'b0,
      sr_en:     1'b0,
      pinsel:    PIN_SELECT_RESET,
      div:       '0,
      ack:       1'b0,
      rdata:     '0
   };

   state_t            state_q;
   state_t            state_d;
   logic [PORT_W-1:0] pin_sync_q;
   logic [ROUTE_N-1:0] route_def_sync;
   logic [ROUTE_N-1:0] route_alt_sync;
   logic [PORT_W-1:0] dig_in_en;
   logic [PORT_W-1:0] pin_read;
   logic              take;
   logic              internal_osc;
   logic              clkout_active;
   logic [DATA_W-1:0] ctrl_word;

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   pin_sync #(
      .W (PORT_W + 2*ROUTE_N)
   ) u_sync (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .ce_i  (ce_i),
      .d_i   ({route_pin_alt_i, route_pin_default_i, port_a_pin_i}),
      .q_o   ({route_alt_sync, route_def_sync, pin_sync_q})
   );

   // ---------------------------------------------------------------
   // Oscillator pin modes
   // ---------------------------------------------------------------
   assign internal_osc  = (state_q.osc == OSC_INTERNAL);
   assign clkout_active = (state_q.osc == OSC_RC) || (internal_osc && state_q.clkout_en);

   // Digital input buffer gating per pin
   always_comb begin
      dig_in_en = ~state_q.analog_select_register;
      dig_in_en[PIN_DAC]    = ~state_q.analog_select_register[PIN_DAC] & ~state_q.dac_en;
      dig_in_en[PIN_UNIT5]  = 1'b1;
      dig_in_en[PIN_CLKOUT] = internal_osc & ~state_q.clkout_en;
      dig_in_en[PIN_OSC_IN] = internal_osc;
   end

   assign pin_read = pin_sync_q & dig_in_en;

   // ---------------------------------------------------------------
   // Pin drivers
   // ---------------------------------------------------------------
   always_comb begin
      port_a_out_o = state_q.lat;
      port_a_oe_o  = ~state_q.dir;
      port_a_oe_o[PIN_DAC] = ~state_q.dir[PIN_DAC] & ~state_q.dac_en;
      // Priority on bit 4: SR latch, then unit5, then latch
      if (state_q.sr_en) begin
         port_a_out_o[PIN_UNIT5] = sr_latch_true_out_i;
      end else if (state_q.unit5_en) begin
         port_a_out_o[PIN_UNIT5] = unit5_out_i;
      end
      if (clkout_active) begin
         port_a_out_o[PIN_CLKOUT] = state_q.div[CLKOUT_DIV_W-1];
         port_a_oe_o[PIN_CLKOUT]  = 1'b1;
      end else if (!internal_osc) begin
         // Crystal amplifier owns the pin in external modes
         port_a_oe_o[PIN_CLKOUT]  = 1'b0;
      end
      if (!internal_osc) begin
         port_a_oe_o[PIN_OSC_IN] = 1'b0;
      end
   end

   assign analog_connect_o       = state_q.dir & state_q.analog_select_register;
   assign dac_reference_output_o = state_q.dac_en & state_q.analog_select_register[PIN_DAC];

   // ---------------------------------------------------------------
   // Peripheral pin routing
   // ---------------------------------------------------------------
   for (genvar g = 0; g < ROUTE_N; g++) begin : g_route
      route_select u_route (
         .sel_default_i (state_q.pinsel[g]),
         .periph_out_i  (route_periph_out_i[g]),
         .periph_oe_i   (route_periph_oe_i[g]),
         .pin_default_i (route_def_sync[g]),
         .pin_alt_i     (route_alt_sync[g]),
         .default_out_o (route_default_out_o[g]),
         .default_oe_o  (route_default_oe_o[g]),
         .alt_out_o     (route_alt_out_o[g]),
         .alt_oe_o      (route_alt_oe_o[g]),
         .periph_in_o   (route_periph_in_o[g])
      );
   end

   // ---------------------------------------------------------------
   // Register file and next state
   // ---------------------------------------------------------------
   assign take = cyc_i && stb_i && !state_q.ack;

   always_comb begin
      ctrl_word = '0;
      ctrl_word[CTRL_OSC_LSB +: 2]              = state_q.osc;
      ctrl_word[CTRL_CLKOUT_BIT]                = state_q.clkout_en;
      ctrl_word[CTRL_DAC_BIT]                   = state_q.dac_en;
      ctrl_word[CTRL_UNIT5_BIT]                 = state_q.unit5_en;
      ctrl_word[CTRL_SR_BIT]                    = state_q.sr_en;
      ctrl_word[CTRL_PINSEL_LSB +: ROUTE_N]     = state_q.pinsel;
   end

   always_comb begin
      state_d     = state_q;
      state_d.div = CLKOUT_DIV_W'(state_q.div + 1'b1);
      state_d.ack = take;
      if (take) begin
         state_d.rdata = '0;
         case (adr_i)
            OFS_PIN_VALUES: state_d.rdata[PORT_W-1:0] = pin_read;
            OFS_OUT_LATCH:  state_d.rdata[PORT_W-1:0] = state_q.lat;
            OFS_DIRECTION:  state_d.rdata[PORT_W-1:0] = state_q.dir;
            OFS_ANALOG_SEL: state_d.rdata[PORT_W-1:0] = state_q.analog_select_register;
            OFS_CONTROL:    state_d.rdata = ctrl_word;
            default:        state_d.rdata = '0;
         endcase
         if (we_i) begin
            case (adr_i)
               OFS_PIN_VALUES, OFS_OUT_LATCH: begin
                  if (sel_i[0]) state_d.lat = dat_i[PORT_W-1:0];
               end
               OFS_DIRECTION: begin
                  if (sel_i[0]) state_d.dir = dat_i[PORT_W-1:0];
               end
               OFS_ANALOG_SEL: begin
                  if (sel_i[0]) state_d.analog_select_register = dat_i[PORT_W-1:0] & ANALOG_IMPL_MASK;
               end
               OFS_CONTROL: begin
                  if (sel_i[0]) begin
                     state_d.osc       = osc_mode_t'(dat_i[CTRL_OSC_LSB +: 2]);
                     state_d.clkout_en = dat_i[CTRL_CLKOUT_BIT];
                     state_d.dac_en    = dat_i[CTRL_DAC_BIT];
                     state_d.unit5_en  = dat_i[CTRL_UNIT5_BIT];
                     state_d.sr_en     = dat_i[CTRL_SR_BIT];
                     state_d.pinsel[1:0] = dat_i[CTRL_PINSEL_LSB +: 2];
                  end
                  if (sel_i[1]) state_d.pinsel[3:2] = dat_i[CTRL_PINSEL_LSB+2 +: 2];
               end
               default: ;
            endcase
         end
      end
   end

   // Power-on and brown-out both arrive on rst_i
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= STATE_RESET;
      end else if (ce_i) begin
         state_q <= state_d;
      end
   end

   assign dat_o = state_q.rdata;
   assign ack_o = state_q.ack;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   logic read_pin_taken;
   assign read_pin_taken = take && !we_i && (adr_i == OFS_PIN_VALUES) && ce_i;

   a_analog_reads_zero: assert property (@(posedge clk_i) disable iff (rst_i)
      read_pin_taken |=> ((dat_o[PORT_W-1:0] & $past(state_q.analog_select_register)) == '0) && ack_o)
      else $error("analog pin read back nonzero");

   a_output_ignores_analog: assert property (@(posedge clk_i) disable iff (rst_i)
      (!state_q.dir[0] && state_q.analog_select_register[0]) |-> (port_a_oe_o[0] && port_a_out_o[0] == state_q.lat[0]))
      else $error("analog select altered output drive");

   a_reset_defaults: assert property (@(posedge clk_i)
      $past(rst_i) |-> (state_q.analog_select_register == ANALOG_RESET && state_q.dir == DIRECTION_RESET
                        && port_a_oe_o == '0 && analog_connect_o == ANALOG_RESET))
      else $error("reset defaults wrong");

   a_bit4_digital_in: assert property (@(posedge clk_i) disable iff (rst_i)
      read_pin_taken ##1 1'b1 |-> dat_o[PIN_UNIT5] == $past(pin_sync_q[PIN_UNIT5]))
      else $error("bit4 input not digital");

   a_latch_drive: assert property (@(posedge clk_i) disable iff (rst_i)
      (!state_q.dir[1] && !state_q.analog_select_register[1]) |-> port_a_oe_o[1] && port_a_out_o[1] == state_q.lat[1])
      else $error("latch not driven on output pin");

   a_unit5_priority: assert property (@(posedge clk_i) disable iff (rst_i)
      (state_q.unit5_en && !state_q.sr_en && !state_q.dir[PIN_UNIT5])
         |-> port_a_oe_o[PIN_UNIT5] && port_a_out_o[PIN_UNIT5] == unit5_out_i)
      else $error("unit5 output lost priority");

   a_sr_priority: assert property (@(posedge clk_i) disable iff (rst_i)
      (state_q.sr_en && state_q.unit5_en) |-> port_a_out_o[PIN_UNIT5] == sr_latch_true_out_i)
      else $error("sr latch output lost priority");

   a_dac_blocks_bit2: assert property (@(posedge clk_i) disable iff (rst_i)
      state_q.dac_en |-> !port_a_oe_o[PIN_DAC] && !pin_read[PIN_DAC])
      else $error("bit2 digital active under dac");

   a_bit6_gated: assert property (@(posedge clk_i) disable iff (rst_i)
      (!internal_osc || state_q.clkout_en) |-> !pin_read[PIN_CLKOUT])
      else $error("bit6 digital input active in wrong mode");

   sequence s_two_enabled;
      ce_i ##1 ce_i;
   endsequence

   a_clkout_quarter: assert property (@(posedge clk_i) disable iff (rst_i)
      ((state_q.osc == OSC_RC) && $rose(port_a_out_o[PIN_CLKOUT])) ##0 s_two_enabled
         |=> !port_a_out_o[PIN_CLKOUT])
      else $error("clock out high phase not two cycles");

   a_bit7_external_off: assert property (@(posedge clk_i) disable iff (rst_i)
      !internal_osc |-> !port_a_oe_o[PIN_OSC_IN] && !pin_read[PIN_OSC_IN])
      else $error("bit7 digital active in external oscillator");

   a_route_default: assert property (@(posedge clk_i) disable iff (rst_i)
      state_q.pinsel[ROUTE_UNIT2] |-> (route_default_oe_o[ROUTE_UNIT2] == route_periph_oe_i[ROUTE_UNIT2])
                                      && !route_alt_oe_o[ROUTE_UNIT2])
      else $error("unit2 not on default pin");

   a_port_write_latch: assert property (@(posedge clk_i) disable iff (rst_i)
      (take && ce_i && we_i && sel_i[0] && adr_i == OFS_PIN_VALUES)
         |=> state_q.lat == $past(dat_i[PORT_W-1:0]))
      else $error("port write missed latch");

   a_sync_two_stage: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i ##1 ce_i) |=> pin_sync_q == $past(port_a_pin_i, 2))
      else $error("pin input not two flops deep");

   a_input_reads_level: assert property (@(posedge clk_i) disable iff (rst_i)
      (read_pin_taken && state_q.dir[0] && !state_q.analog_select_register[0]) |=> dat_o[0] == $past(pin_sync_q[0]))
      else $error("digital input pin read wrong level");

   a_analog_needs_both: assert property (@(posedge clk_i) disable iff (rst_i)
      analog_connect_o[1] |-> state_q.dir[1] && state_q.analog_select_register[1])
      else $error("analog path connected without input and select");

   a_bit4_reset_input: assert property (@(posedge clk_i)
      $past(rst_i) |-> !port_a_oe_o[PIN_UNIT5] && dig_in_en[PIN_UNIT5])
      else $error("bit4 not a digital input after reset");

   a_dac_output_gate: assert property (@(posedge clk_i) disable iff (rst_i)
      dac_reference_output_o |-> state_q.dac_en && state_q.analog_select_register[PIN_DAC] && !port_a_oe_o[PIN_DAC])
      else $error("dac output with bit2 digital drive");

   a_bit6_plain_io: assert property (@(posedge clk_i) disable iff (rst_i)
      (internal_osc && !state_q.clkout_en)
         |-> (port_a_oe_o[PIN_CLKOUT] == !state_q.dir[PIN_CLKOUT])
             && (port_a_out_o[PIN_CLKOUT] == state_q.lat[PIN_CLKOUT])
             && (pin_read[PIN_CLKOUT] == pin_sync_q[PIN_CLKOUT]))
      else $error("bit6 not plain digital in internal mode");

   a_route_alternate: assert property (@(posedge clk_i) disable iff (rst_i)
      !state_q.pinsel[ROUTE_PWM2B]
         |-> (route_alt_oe_o[ROUTE_PWM2B] == route_periph_oe_i[ROUTE_PWM2B]) && !route_default_oe_o[ROUTE_PWM2B])
      else $error("pwm2b not on alternate pin");

   a_freeze_on_ce: assert property (@(posedge clk_i) disable iff (rst_i)
      !ce_i |=> $stable(state_q.lat) && $stable(state_q.div) && $stable(pin_sync_q))
      else $error("state moved while clock enable low");

endmodule // port_a_ctrl
`default_nettype wire

// ### test/board_model.sv
`timescale 1ns/1ps
`default_nettype none
module board_model (
   input  wire logic [7:0] out_i,
   input  wire logic [7:0] oe_i,
   input  wire logic [7:0] ext_i,
   output logic      [7:0] pin_o
);
   // Board has no pulls: a released pad shows whatever the bench
   // puts on it, and the bench changes that pattern every step
   assign pin_o = (oe_i & out_i) | (~oe_i & ext_i);
endmodule // board_model
`default_nettype wire

// ### test/port_pin_analog_digital_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module port_pin_analog_digital_control_tb;
   import port_pkg::*;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        ce    = 1'b1;
   logic        cyc   = 1'b0;
   logic        stb   = 1'b0;
   logic        we    = 1'b0;
   logic [7:0]  adr   = 8'h00;
   logic [3:0]  sel   = 4'h0;
   logic [31:0] wdat  = 32'h0;
   logic [7:0]  ext   = 8'h00;
   logic        u5    = 1'b0;
   logic        sr    = 1'b0;
   logic [3:0]  pout  = 4'h0;
   logic [3:0]  poe   = 4'h0;
   logic [3:0]  rdef  = 4'h0;
   logic [3:0]  ralt  = 4'h0;
   logic [15:0] seed  = 16'h0029;
   logic [31:0] rdat, dat_o;
   logic [7:0]  pin, out_o, oe_o, acon, lat_m, dir_m, ans_m;
   logic [9:0]  ctl_m;
   logic [3:0]  dout, doe, aout, aoe, pin_in;
   logic        ack_o, dac_o;
   int          miscompares = 0;
   int          num_checks = 0;

   always #5 clk_i = ~clk_i;

   port_a_ctrl DUT (
      .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
      .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
      .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o),
      .port_a_pin_i(pin), .port_a_out_o(out_o), .port_a_oe_o(oe_o),
      .analog_connect_o(acon), .dac_reference_output_o(dac_o),
      .unit5_out_i(u5), .sr_latch_true_out_i(sr),
      .route_periph_out_i(pout), .route_periph_oe_i(poe),
      .route_pin_default_i(rdef), .route_pin_alt_i(ralt),
      .route_default_out_o(dout), .route_default_oe_o(doe),
      .route_alt_out_o(aout), .route_alt_oe_o(aoe),
      .route_periph_in_o(pin_in)
   );

   board_model BRD (.out_i(out_o), .oe_i(oe_o), .ext_i(ext), .pin_o(pin));

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [15:0] rnd();
      seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
      return seed;
   endfunction

   task automatic wrap_up();
      if (miscompares == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   task automatic cmp32(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e) begin
         miscompares++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
      cmp32({24'h0, g}, {24'h0, e});
   endtask

   // Classic cycle; only the watchdog limits the wait for ack
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
      @(posedge clk_i);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      sel  <= s;
      do begin
         @(posedge clk_i);
      end while (ack_o !== 1'b1);
      rdat = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0, 4'hf);
      cmp32(rdat, e);
   endtask

   task automatic cfg(input logic [7:0] l, input logic [7:0] d,
                      input logic [7:0] a, input logic [9:0] c);
      lat_m = l;
      dir_m = d;
      ans_m = a & ANALOG_IMPL_MASK;
      ctl_m = c;
      wb(1'b1, OFS_OUT_LATCH, {24'h0, l}, 4'hf);
      wb(1'b1, OFS_DIRECTION, {24'h0, d}, 4'hf);
      wb(1'b1, OFS_ANALOG_SEL, {24'h0, a}, 4'hf);
      wb(1'b1, OFS_CONTROL, {22'h0, c}, 4'hf);
   endtask

   // ---------------------------------------------------------------
   // Reference model of the pads
   // ---------------------------------------------------------------
   task automatic check_pins();
      logic [7:0] oe_e, out_e, en_e, msk;
      logic [3:0] ps, de;
      logic       ck;
      ck    = ctl_m[1:0] == 2'd1 || (ctl_m[1:0] == 2'd0 && ctl_m[2]);
      ps    = ctl_m[9:6];
      de    = ps & poe;
      oe_e  = ~dir_m;
      out_e = lat_m;
      en_e  = ~ans_m | ~ANALOG_IMPL_MASK;
      if (ctl_m[3]) {oe_e[2], en_e[2]} = 2'b00;
      if (!dir_m[4]) out_e[4] = ctl_m[5] ? sr : (ctl_m[4] ? u5 : lat_m[4]);
      if (ctl_m[1:0] != 2'd0 || ctl_m[2]) en_e[6] = 1'b0;
      if (ctl_m[1]) oe_e[7:6] = 2'b00;
      if (ctl_m[1]) en_e[7] = 1'b0;
      if (ck) oe_e[6] = 1'b1;
      msk = ck ? 8'hbf : 8'hff;
      // Let the two-flop input path settle before judging reads
      repeat (4) @(posedge clk_i);
      #1;
      cmp8(oe_o, oe_e);
      cmp8(out_o & oe_e & msk, out_e & oe_e & msk);
      cmp8(acon, dir_m & ans_m);
      cmp8({7'h0, dac_o}, {7'h0, ctl_m[3] & ans_m[2]});
      cmp32({12'h0, doe, aoe, dout & doe, aout & aoe, pin_in},
            {12'h0, de, ~ps & poe, pout & de, pout & ~ps & poe, (ps & rdef) | (~ps & ralt)});
      rd_chk(OFS_PIN_VALUES, {24'h0, ((oe_e & out_e) | (~oe_e & ext)) & en_e & msk});
   endtask

   task automatic reset_chk();
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      lat_m = 8'h00;
      dir_m = 8'hff;
      ans_m = ANALOG_IMPL_MASK;
      ctl_m = 10'h3c0;
      rd_chk(OFS_DIRECTION, 32'hff);
      rd_chk(OFS_ANALOG_SEL, {24'h0, ANALOG_IMPL_MASK});
      rd_chk(OFS_CONTROL, 32'h3c0);
      check_pins();
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   initial begin
      logic [15:0] r, q, p;
      logic [9:0]  c;
      logic [7:0]  s, e;
      reset_chk();
      rd_chk(8'h40, 32'h0);
      wb(1'b1, OFS_PIN_VALUES, 32'h5a, 4'hf);
      rd_chk(OFS_OUT_LATCH, 32'h5a);
      wb(1'b1, OFS_OUT_LATCH, 32'ha5, 4'h0);
      rd_chk(OFS_OUT_LATCH, 32'h5a);
      for (int i = 0; i < 40; i++) begin
         r = rnd();
         q = rnd();
         p = rnd();
         @(posedge clk_i);
         ext  <= r[7:0];
         u5   <= r[8];
         sr   <= r[9];
         pout <= r[13:10];
         poe  <= q[3:0];
         rdef <= q[7:4];
         ralt <= p[15:12];
         c = p[9:0];
         // RC mode is judged on its own below
         if (c[1:0] == 2'd1) c[1:0] = 2'd0;
         cfg(q[7:0], q[15:8], r[15:8], c);
         check_pins();
      end
      cfg(8'h00, 8'hff, 8'h2f, 10'h3c1);
      repeat (4) @(posedge clk_i);
      for (int k = 0; k < 8; k++) begin
         @(posedge clk_i);
         #1;
         s[k] = out_o[6];
      end
      e = 8'h33;
      for (int k = 0; k < 4; k++) if (s == 8'(16'h3333 >> k)) e = s;
      cmp8(s, e);
      cmp8({7'h0, oe_o[6]}, 8'h01);
      // Clock enable low must hold the divider, so the clock pin stops
      @(posedge clk_i);
      ce <= 1'b0;
      @(posedge clk_i);
      #1;
      s[0] = out_o[6];
      repeat (6) @(posedge clk_i);
      #1;
      cmp8({7'h0, out_o[6]}, {7'h0, s[0]});
      @(posedge clk_i);
      ce <= 1'b1;
      reset_chk();
      wrap_up();
   end

   initial begin
      #200000;
      miscompares++;
      wrap_up();
   end
endmodule // port_pin_analog_digital_control_tb
`default_nettype wire
